// ---- rtl/cs_decoder_defines.vh ----
// Constants for the chip-select decoder: register offsets, field positions,
// reset values and timing counts. Assumes inclusion by bare name.
`ifndef CS_DECODER_DEFINES_VH
`define CS_DECODER_DEFINES_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define OFS_CFG0          8'h00
`define OFS_CFG4          8'h10
`define OFS_REMAP         8'h20
`define OFS_STATUS        8'h24
`define OFS_ABORT_ADDR    8'h28

// ----------------------------------------
// Config register fields
// ----------------------------------------
`define BASE_HI           31
`define BASE_LO           20
`define EN_BIT            13
`define BAT_BIT           12
`define TDF_HI            11
`define TDF_LO            9
`define PAGE_HI           8
`define PAGE_LO           7
`define WSE_BIT           5
`define NWS_HI            4
`define NWS_LO            2
`define DBW_HI            1
`define DBW_LO            0
`define CFG_USED_MASK     32'hFFF03FBF
`define CFG0_RESET        32'h00002000
`define CFGN_RESET        32'h00000000
`define REMAP_BIT         0

// ----------------------------------------
// Address map
// ----------------------------------------
`define BOOT_VECTOR       32'h00000000
`define BOOT_WINDOW_BITS  20
`define REGION_BITS       24
`define RAM_MIRROR_BASE   24'h800000
`define RAM_DEV_SEL_HI    22
`define RAM_DEV_SEL_LO    21

// ----------------------------------------
// Timing: bus clock of 32 MHz in half-clock phases
// ----------------------------------------
`define BUS_CYCLE_PS      31250
`define BUS_CYCLE_3WS_PS  125000
`define NUM_SELECTS       5

`endif

// ---- rtl/bus_cycle_timer.v ----
// Bus cycle timer: generates strobe and cycle lengths from the wait settings.
// Assumes one clock; start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`include "cs_decoder_defines.vh"

module bus_cycle_timer (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire       start,
   input  wire       wait_enable,
   input  wire [2:0] wait_count,
   input  wire [2:0] float_time,
   input  wire       ext_wait_b,
   output reg        strobe,
   output wire       busy,
   output reg        done
);

   // ----------------------------------------
   // Phases in half clocks: zero wait is 2 halves strobe; one wait adds
   // 1 strobe half and 1 hold half; each further wait adds 2 strobe halves
   // ----------------------------------------
   localparam ST_IDLE  = 2'd0;
   localparam ST_STRB  = 2'd1;
   localparam ST_HOLD  = 2'd2;
   localparam ST_FLOAT = 2'd3;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [4:0] cnt_reg;
   reg [4:0] cnt_next;
   reg [4:0] strobe_len;
   reg       hold_half;

   always @* begin
      strobe_len = 5'h02;
      hold_half  = 1'b0;
      if (wait_enable && (wait_count != 3'h0)) begin
         strobe_len = 5'h03 + {1'b0, (wait_count - 3'h1), 1'b0};
         hold_half  = 1'b1;
      end
   end

   assign busy = (state_reg != ST_IDLE);

   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_STRB;
               cnt_next   = strobe_len - 5'h01;
            end
         end
         ST_STRB: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else if (!ext_wait_b) begin
               cnt_next = 5'h00;
            end else if (hold_half) begin
               state_next = ST_HOLD;
            end else if (float_time != 3'h0) begin
               // No hold half here: one more count keeps the released bus
               // float as long as after a hold, since the selects lag a clock
               state_next = ST_FLOAT;
               cnt_next   = {1'b0, float_time, 1'b0};
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (float_time != 3'h0) begin
               state_next = ST_FLOAT;
               cnt_next   = {1'b0, float_time, 1'b0} - 5'h01;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_FLOAT: begin
            if (cnt_reg != 5'h00) begin
               cnt_next = cnt_reg - 5'h01;
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 5'h00;
         strobe    <= 1'b0;
         done      <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         strobe    <= (state_next == ST_STRB);
         done      <= busy && (state_next == ST_IDLE);
      end
   end

endmodule

// ---- rtl/chip_select_memory_decoder.v ----
// Chip-select decoder with AHB-Lite register slave and external bus port.
// Assumes one 32 MHz bus clock in hardware; sys_clk counts half-clock phases.
`timescale 1ns/1ps
`include "cs_decoder_defines.vh"

module chip_select_memory_decoder (
   input  wire        sys_clk,
   input  wire        rst_b,
   // AHB-Lite register slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   // Straps
   input  wire        ram_size_strap_a,
   input  wire        ram_size_strap_b,
   input  wire [1:0]  ethernet_select_option,
   input  wire        decode_logic_fitted,
   // Processor-side memory access
   input  wire        mem_req,
   input  wire [31:0] mem_addr,
   input  wire        mem_write,
   input  wire        ext_wait_b,
   output wire [31:0] boot_vector,
   output wire        mem_busy,
   output reg         mem_done,
   output reg         data_abort,
   // External bus
   output reg  [23:0] ext_addr,
   output reg  [3:0]  ram_device_select_b,
   output reg         flash_select_b,
   output reg         ram_select_b,
   output reg         select_two_b,
   output reg         select_three_b,
   output reg         select_four_b,
   output reg         ethernet_select_b,
   output reg         read_strobe_b,
   output reg         write_strobe_b,
   output reg         byte_access_type,
   output reg  [1:0]  page_size_field,
   output reg  [1:0]  bus_width_code
);

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   reg [31:0] cfg_reg [0:`NUM_SELECTS-1];
   reg        remap_reg;
   reg        strap_a_reg;
   reg        strap_b_reg;
   reg [1:0]  eth_opt_reg;
   reg        strap_taken_reg;
   reg [31:0] abort_addr_reg;
   reg        abort_flag_reg;

   reg        wr_pend_reg;
   reg [7:0]  wr_addr_reg;
   reg        rd_pend_reg;
   reg [7:0]  rd_addr_reg;

   wire       bus_take = hsel && hready && htrans[1];
   wire       abort_set;

   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign boot_vector = `BOOT_VECTOR;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= bus_take && hwrite;
         rd_pend_reg <= bus_take && !hwrite;
         if (bus_take) begin
            wr_addr_reg <= haddr[7:0];
            rd_addr_reg <= haddr[7:0];
         end
      end
   end

   // Straps caught on the first clock after release, never by the reset itself
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_taken_reg <= 1'b0;
         strap_a_reg     <= 1'b1;
         strap_b_reg     <= 1'b1;
         eth_opt_reg     <= 2'h0;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         strap_a_reg     <= ram_size_strap_a;
         strap_b_reg     <= ram_size_strap_b;
         eth_opt_reg     <= ethernet_select_option;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SELECTS; gi = gi + 1) begin : g_cfg
         always @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               cfg_reg[gi] <= (gi == 0) ? `CFG0_RESET : `CFGN_RESET;
            end else if (wr_pend_reg && (wr_addr_reg == (`OFS_CFG0 + gi * 4))) begin
               cfg_reg[gi] <= hwdata & `CFG_USED_MASK;
            end
         end
      end
   endgenerate

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         remap_reg      <= 1'b0;
         abort_flag_reg <= 1'b0;
         abort_addr_reg <= 32'h00000000;
      end else begin
         if (wr_pend_reg && (wr_addr_reg == `OFS_REMAP) && hwdata[`REMAP_BIT]) begin
            remap_reg <= 1'b1;
         end
         // New abort wins over a clear in the same cycle
         if (abort_set) begin
            abort_flag_reg <= 1'b1;
            abort_addr_reg <= mem_addr;
         end else if (wr_pend_reg && (wr_addr_reg == `OFS_STATUS) && hwdata[0]) begin
            abort_flag_reg <= 1'b0;
         end
      end
   end

   always @* begin
      hrdata = 32'h00000000;
      if (rd_pend_reg) begin
         case (rd_addr_reg)
            8'h00:          hrdata = cfg_reg[0];
            8'h04:          hrdata = cfg_reg[1];
            8'h08:          hrdata = cfg_reg[2];
            8'h0C:          hrdata = cfg_reg[3];
            `OFS_CFG4:      hrdata = cfg_reg[4];
            `OFS_REMAP:     hrdata = {31'h00000000, remap_reg};
            `OFS_STATUS:    hrdata = {24'h000000, eth_opt_reg, strap_b_reg, strap_a_reg,
                                      2'h0, remap_reg, abort_flag_reg};
            `OFS_ABORT_ADDR: hrdata = abort_addr_reg;
            default:        hrdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   reg [`NUM_SELECTS-1:0] hit;
   reg [2:0]              hit_idx;
   integer                k;

   always @* begin
      hit     = {`NUM_SELECTS{1'b0}};
      hit_idx = 3'h0;
      if (!remap_reg) begin
         hit[0] = (mem_addr[31:`BOOT_WINDOW_BITS] == 12'h000);
      end else begin
         for (k = 0; k < `NUM_SELECTS; k = k + 1) begin
            hit[k] = cfg_reg[k][`EN_BIT] &&
                     (mem_addr[31:`REGION_BITS] ==
                      cfg_reg[k][`BASE_HI:`REGION_BITS]);
         end
      end
      for (k = `NUM_SELECTS - 1; k >= 0; k = k - 1) begin
         if (hit[k]) begin
            hit_idx = k[2:0];
         end
      end
   end

   assign abort_set = mem_req && !mem_busy && (hit == {`NUM_SELECTS{1'b0}});

   // RAM device within the mirror area; straps select fitted size
   reg [23:0] ram_offset;
   reg [3:0]  ram_dev;
   always @* begin
      ram_offset = mem_addr[23:0];
      ram_dev    = 4'hF;
      if (decode_logic_fitted && (mem_addr[23] == `RAM_MIRROR_BASE >> 23)) begin
         ram_dev = ~(4'h1 << mem_addr[`RAM_DEV_SEL_HI:`RAM_DEV_SEL_LO]);
         case ({strap_b_reg, strap_a_reg})
            2'b11:   ram_offset = {5'h00, mem_addr[18:0]};
            2'b10:   ram_offset = {4'h0, mem_addr[19:0]};
            2'b01:   ram_offset = {3'h0, mem_addr[20:0]};
            default: ram_offset = {3'h0, mem_addr[20:0]};
         endcase
      end
   end

   // ----------------------------------------
   // Access sequencing
   // ----------------------------------------
   reg  [2:0] act_idx_reg;
   reg        act_write_reg;
   wire       start = mem_req && !mem_busy && (hit != {`NUM_SELECTS{1'b0}});
   wire       strobe;
   wire       tmr_done;
   wire       tmr_busy;

   // Busy until the registered strobes are back high, so no new request
   // can be taken while the bus still shows the last access
   assign mem_busy = tmr_busy || !(read_strobe_b && write_strobe_b);
   wire [31:0] act_cfg = cfg_reg[act_idx_reg];

   bus_cycle_timer u_timer (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .start       (start),
      .wait_enable (cfg_reg[hit_idx][`WSE_BIT]),
      .wait_count  (cfg_reg[hit_idx][`NWS_HI:`NWS_LO]),
      .float_time  (cfg_reg[hit_idx][`TDF_HI:`TDF_LO]),
      .ext_wait_b  (ext_wait_b),
      .strobe      (strobe),
      .busy        (tmr_busy),
      .done        (tmr_done)
   );

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         act_idx_reg         <= 3'h0;
         act_write_reg       <= 1'b0;
         ext_addr            <= 24'h000000;
         ram_device_select_b <= 4'hF;
         mem_done            <= 1'b0;
         data_abort          <= 1'b0;
      end else begin
         mem_done   <= tmr_done;
         data_abort <= abort_set;
         if (start) begin
            act_idx_reg   <= hit_idx;
            act_write_reg <= mem_write;
            ext_addr      <= (hit_idx == 3'h1) ? ram_offset : mem_addr[23:0];
            ram_device_select_b <= (hit_idx == 3'h1) ? ram_dev : 4'hF;
         end else if (!mem_busy) begin
            ram_device_select_b <= 4'hF;
         end
      end
   end

   // Selects follow the strobe so float time leaves the bus released
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_select_b    <= 1'b1;
         ram_select_b      <= 1'b1;
         select_two_b      <= 1'b1;
         select_three_b    <= 1'b1;
         select_four_b     <= 1'b1;
         ethernet_select_b <= 1'b1;
         read_strobe_b     <= 1'b1;
         write_strobe_b    <= 1'b1;
         byte_access_type  <= 1'b0;
         page_size_field   <= 2'h0;
         bus_width_code    <= 2'h0;
      end else begin
         flash_select_b    <= !(strobe && act_idx_reg == 3'h0);
         ram_select_b      <= !(strobe && act_idx_reg == 3'h1);
         select_two_b      <= !(strobe && act_idx_reg == 3'h2);
         select_three_b    <= !(strobe && act_idx_reg == 3'h3);
         select_four_b     <= !(strobe && act_idx_reg == 3'h4);
         ethernet_select_b <= !(strobe &&
                               act_idx_reg == (3'h2 + {1'b0, eth_opt_reg}));
         read_strobe_b     <= !(strobe && !act_write_reg);
         write_strobe_b    <= !(strobe && act_write_reg);
         byte_access_type  <= act_cfg[`BAT_BIT];
         page_size_field   <= act_cfg[`PAGE_HI:`PAGE_LO];
         bus_width_code    <= act_cfg[`DBW_HI:`DBW_LO];
      end
   end

endmodule

// ---- dv/ext_mem_model.sv ----
// Far-side wait source standing for a slow memory or controller.
// Assumes the decoder strobes; a pull-up keeps the wait line idle high.
`timescale 1ns/1ps
module ext_mem_model (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire       read_strobe_b,
   input  wire       write_strobe_b,
   input  wire [3:0] wait_hold,
   output wire       ext_wait_b
);
   // ----------------------------------------
   // Wait generation
   // ----------------------------------------
   reg  [3:0] low_cnt_reg;
   wire       strb = !(read_strobe_b && write_strobe_b);

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_reg <= 4'h0;
      end else begin
         low_cnt_reg <= !strb ? 4'h0 : (&low_cnt_reg ? low_cnt_reg : low_cnt_reg + 4'h1);
      end
   end

   // Released to the pull-up once the hold runs out or the strobe ends
   assign ext_wait_b = !(strb && (low_cnt_reg < wait_hold));
endmodule

// ---- dv/cs_decoder_asserts.sv ----
// Port-level checker of the chip-select decoder.
// Assumes binding to the decoder top module.
`timescale 1ns/1ps
module cs_decoder_asserts (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire        mem_req,
   input  wire        mem_busy,
   input  wire        mem_done,
   input  wire        data_abort,
   input  wire        ext_wait_b,
   input  wire [31:0] boot_vector,
   input  wire [3:0]  ram_device_select_b,
   input  wire        flash_select_b,
   input  wire        ram_select_b,
   input  wire        select_two_b,
   input  wire        select_three_b,
   input  wire        select_four_b,
   input  wire        read_strobe_b,
   input  wire        write_strobe_b
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   wire [4:0] sel  = ~{select_four_b, select_three_b, select_two_b, ram_select_b, flash_select_b};
   wire       strb = !(read_strobe_b && write_strobe_b);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   AST_BOOT: assert property (boot_vector == 32'h00000000)
      else $error("boot vector not zero");
   AST_ONE_SEL: assert property ($onehot0(sel))
      else $error("several selects active");
   AST_SEL_BUSY: assert property (sel != 5'h00 |-> mem_busy)
      else $error("select outside an access");
   AST_STRB_SEL: assert property (strb |-> sel != 5'h00 && mem_busy)
      else $error("strobe without select");
   AST_ABORT_QUIET: assert property (data_abort |-> sel == 5'h00 && !strb)
      else $error("abort with bus activity");
   AST_REQ_ANSWER: assert property (mem_req && !mem_busy |=> mem_busy || data_abort)
      else $error("request neither started nor aborted");
   AST_STRB_MIN: assert property ($rose(strb) |-> strb [*2])
      else $error("strobe shorter than a bus clock");
   AST_WAIT_EXT: assert property (strb && !ext_wait_b |=> strb)
      else $error("strobe ended during external wait");
   AST_DONE: assert property ($fell(mem_busy) |-> ##[0:1] mem_done)
      else $error("no done after access");
   AST_RAM_DEV: assert property ($onehot0(~ram_device_select_b))
      else $error("several ram devices selected");

   COV_ABORT: cover property (data_abort);
   COV_DEV3: cover property (!ram_device_select_b[3]);
   COV_WAIT: cover property (strb && !ext_wait_b);
endmodule

bind chip_select_memory_decoder cs_decoder_asserts i_chk (
   .sys_clk, .rst_b, .mem_req, .mem_busy, .mem_done, .data_abort, .ext_wait_b, .boot_vector,
   .ram_device_select_b, .flash_select_b, .ram_select_b, .select_two_b, .select_three_b,
   .select_four_b, .read_strobe_b, .write_strobe_b
);

// ---- dv/test_chip_select_memory_decoder.sv ----
// Self-checking bench of the chip-select decoder with a wait source.
// Assumes a zero-wait AHB-Lite slave and one clock.
`timescale 1ns/1ps
`include "cs_decoder_defines.vh"
module test_chip_select_memory_decoder;
   // ----------------------------------------
   // Signals and tasks
   // ----------------------------------------
   logic        sys_clk, rst_b, hsel, hwrite, mem_req, mem_write, c_ab, wt_en;
   logic        ram_size_strap_a, ram_size_strap_b, decode_logic_fitted;
   logic [1:0]  htrans, ethernet_select_option;
   logic [2:0]  hsize, wt_cnt;
   logic [3:0]  hold, c_dev;
   logic [4:0]  c_cp;
   logic [5:0]  c_sel;
   logic [7:0]  c_len, c_tail;
   logic [23:0] c_ea, msk;
   logic [31:0] haddr, hwdata, mem_addr, rd, a1, cfg, ca;
   wire  [31:0] hrdata, boot_vector;
   wire  [23:0] ext_addr;
   wire  [3:0]  ram_device_select_b;
   wire  [1:0]  page_size_field, bus_width_code;
   wire         hreadyout, hresp, ext_wait_b, mem_busy, mem_done, data_abort, read_strobe_b;
   wire         flash_select_b, ram_select_b, select_two_b, select_three_b, select_four_b;
   wire         ethernet_select_b, write_strobe_b, byte_access_type;
   wire         hready = hreadyout;
   wire         strb = !(read_strobe_b && write_strobe_b);
   int          miscompares, num_checks, d;

   chip_select_memory_decoder i_dut (
      .sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .ram_size_strap_a, .ram_size_strap_b, .ethernet_select_option,
      .decode_logic_fitted, .mem_req, .mem_addr, .mem_write, .ext_wait_b, .boot_vector,
      .mem_busy, .mem_done, .data_abort, .ext_addr, .ram_device_select_b, .flash_select_b,
      .ram_select_b, .select_two_b, .select_three_b, .select_four_b, .ethernet_select_b,
      .read_strobe_b, .write_strobe_b, .byte_access_type, .page_size_field, .bus_width_code
   );
   ext_mem_model i_wait (
      .sys_clk, .rst_b, .read_strobe_b, .write_strobe_b, .wait_hold(hold), .ext_wait_b
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= dat;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
   endtask

   // Samples 1 ns after each edge so the edge's own updates have landed
   task automatic mem(input logic [31:0] a);
      int n;
      n = 0;
      c_len = 8'h00;
      c_tail = 8'h00;
      c_ab = 1'b0;
      @(posedge sys_clk);
      mem_req <= 1'b1;
      mem_addr <= a;
      mem_write <= a[2];
      @(posedge sys_clk);
      mem_req <= 1'b0;
      while (n < 300) begin
         #1;
         if (data_abort === 1'b1) c_ab = 1'b1;
         if (strb) begin
            if (c_len == 8'h00) begin
               c_sel = ~{ethernet_select_b, select_four_b, select_three_b, select_two_b,
                         ram_select_b, flash_select_b};
               c_ea = ext_addr;
               c_dev = ram_device_select_b;
               c_cp = {byte_access_type, page_size_field, bus_width_code};
            end
            c_len++;
         end else if (c_len != 8'h00 && mem_busy === 1'b1) c_tail++;
         if (mem_done === 1'b1 || c_ab === 1'b1) break;
         @(posedge sys_clk);
         n++;
      end
      if (n >= 300) miscompares++;
   endtask

   function automatic logic [7:0] exp_len(input logic en, input logic [2:0] cnt);
      exp_len = (!en || cnt == 3'h0) ? 8'h02 : 8'h03 + 8'h02 * {5'h00, cnt - 3'h1};
   endfunction

   // ----------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = !sys_clk;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      test_done;
   end

   initial begin
      {rst_b, hsel, hwrite, mem_req, mem_write, decode_logic_fitted} = 6'h00;
      {ram_size_strap_a, ram_size_strap_b, ethernet_select_option, htrans} = 6'h00;
      {hsize, hold, haddr, hwdata, mem_addr} = {3'h2, 4'h0, 96'h0};
      miscompares = 0;
      num_checks = 0;
      void'($urandom(32'h9DFF96F0));
      // One pass per ram strap code 11, 10 and 01 (00 is not driven), each behind a fresh reset
      for (int c = 0; c < 3; c++) begin
         @(posedge sys_clk);
         rst_b <= 1'b0;
         ram_size_strap_a <= (c != 1);
         ram_size_strap_b <= (c != 2);
         ethernet_select_option <= 2'(c);
         decode_logic_fitted <= 1'b0;
         repeat (20) @(posedge sys_clk);
         rst_b <= 1'b1;
         repeat (2) @(posedge sys_clk);
         ahb(1'b0, {24'h0, `OFS_STATUS}, 32'h0);
         check(rd, {24'h0, 2'(c), c != 2, c != 1, 4'h0});
         ahb(1'b0, {24'h0, `OFS_CFG0}, 32'h0);
         check(rd, `CFG0_RESET);
         ahb(1'b0, 32'h0000002C, 32'h0);
         check(rd, 32'h0);
         mem(`BOOT_VECTOR + ($urandom & 32'h000FFFFC));
         check(c_sel, 6'h01);
         mem(32'h00100000);
         check(c_ab, 1'b1);
         mem(32'h01000000);
         check(c_ab, 1'b1);
         ahb(1'b1, {24'h0, `OFS_REMAP}, 32'h1);
         ahb(1'b0, {24'h0, `OFS_STATUS}, 32'h0);
         check(rd[1:0], 2'h3);
         for (int n = 0; n < 5; n++) begin
            wt_en = (n < 4);
            wt_cnt = (n < 4) ? 3'(n) : 3'h3;
            cfg = 32'h01002000 | ($urandom & 32'h00001F83) | {26'h0, wt_en, wt_cnt, 2'h0};
            ahb(1'b1, {24'h0, `OFS_CFG0} + 32'h4, cfg);
            hold <= (n == 2) ? 4'h9 : 4'h0;
            a1 = 32'h01000000 + ($urandom & 32'h007FFFFC);
            mem(a1);
            check(c_sel, 6'h02);
            check(c_ea, a1[23:0]);
            check(c_cp, {cfg[12], cfg[8:7], cfg[1:0]});
            if (n == 2) check(c_len > 8'h09, 1'b1);
            else check(c_len, exp_len(wt_en, wt_cnt));
            check(c_tail, 8'h02 * cfg[11:9]);
         end
         ahb(1'b1, {24'h0, `OFS_CFG0} + 32'(4 * (c + 2)), 32'h20002000);
         mem(32'h20000000 + ($urandom & 32'h00FFFFFC));
         check(c_sel, 6'h20 | (6'h04 << c));
         ca = (c == 2) ? 32'h00000008 : 32'h00000010;
         cfg = {8'h40, 24'($urandom)} & ~32'h00002000;
         ahb(1'b1, ca, cfg);
         ahb(1'b0, ca, 32'h0);
         check(rd, cfg & `CFG_USED_MASK);
         decode_logic_fitted <= 1'b1;
         mem(32'h40000000 + ($urandom & 32'h00FFFFFC));
         check(c_ab, 1'b1);
         d = $urandom % 4;
         msk = (24'h080000 << c) - 24'h1;
         a1 = 32'h01800000 + d * 32'h200000 + ($urandom & 32'h0007FFFC);
         mem(a1);
         check(c_dev, {28'h0, ~(4'h1 << d)});
         mem(a1 + (32'h80000 << c) * ($urandom % (4 >> c)));
         check(c_dev, {28'h0, ~(4'h1 << d)});
         check(c_ea & msk, a1[23:0] & msk);
      end
      test_done;
   end
endmodule
